/* hdl/acqres_defines.svh */
// register indices, field positions, reset values and channel codes of the result bank
`ifndef ACQRES_DEFINES_SVH
`define ACQRES_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define ACQRES_IDX_CELL_FIRST 8'h20
`define ACQRES_IDX_CELL_LAST  8'h2B
`define ACQRES_IDX_STACK      8'h2C
`define ACQRES_IDX_AUX1       8'h2D
`define ACQRES_IDX_AUX2       8'h2E
`define ACQRES_IDX_SUM        8'h2F
`define ACQRES_IDX_MEAS_EN    8'h30

// ----------------------------------------------------------------
// channel codes on the measurement update port
// ----------------------------------------------------------------
`define ACQRES_NUM_CELLS   12
`define ACQRES_NUM_RESULTS 15
`define ACQRES_CH_STACK    4'hC
`define ACQRES_CH_AUX1     4'hD
`define ACQRES_CH_AUX2     4'hE

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define ACQRES_HI_RES_W      14
`define ACQRES_LO_RES_W      12
`define ACQRES_SUM_LSB       4
`define ACQRES_RESULT_RESET  16'h0000
`define ACQRES_SUM_RESET     16'h0000
`define ACQRES_MEAS_EN_RESET 12'hFFF

`endif

/* hdl/acqres_pkg.sv */
// types shared by the acquisition result bank
package acqres_pkg;

	// ----------------------------------------------------------------
	// measurement update strobe from the conversion sequencer
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic [3:0]  channel;
		logic [13:0] data;
	} acqres_meas_t;

	// ----------------------------------------------------------------
	// apb request and answer
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} acqres_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} acqres_apb_rsp_t;

	typedef logic [15:0] acqres_word_t;

	typedef enum logic [1:0] {
		ACQRES_IDLE,
		ACQRES_ACCESS
	} acqres_apb_state_t;

endpackage : acqres_pkg

/* hdl/acqres_sum.sv */
// sum of the upper twelve bits of every enabled cell result
`timescale 1ns/1ns
`include "acqres_defines.svh"

module acqres_sum (
	// cell results and enables
	input  wire acqres_pkg::acqres_word_t [`ACQRES_NUM_CELLS-1:0] cells,
	input  wire logic [`ACQRES_NUM_CELLS-1:0]                     enable,
	// total
	output logic [15:0]                                           total
);

	logic [`ACQRES_NUM_CELLS-1:0][15:0] term;

	// mask each cell's upper twelve bits by its enable
	genvar g;
	generate
		for (g = 0; g < `ACQRES_NUM_CELLS; g++) begin : g_term
			assign term[g] = enable[g] ? {4'h0, cells[g][15:`ACQRES_SUM_LSB]} : 16'h0000;
		end
	endgenerate

	// twelve terms of at most 0xFFF never pass 16 bits
	always_comb begin
		total = 16'h0000;
		for (int i = 0; i < `ACQRES_NUM_CELLS; i++) begin
			total = total + term[i];
		end
	end

endmodule : acqres_sum

/* hdl/acqres_regs.sv */
// acquisition result register bank with apb slave
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "acqres_defines.svh"


module acqres_regs (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire acqres_pkg::acqres_apb_req_t apb_req,
	output acqres_pkg::acqres_apb_rsp_t      apb_rsp,
	// measurement updates
	input  wire acqres_pkg::acqres_meas_t    meas
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	acqres_pkg::acqres_word_t [`ACQRES_NUM_RESULTS-1:0] result;
	logic [`ACQRES_NUM_CELLS-1:0]                       channel_measure_enable;
	logic [15:0]                                        sum_now;
	logic [15:0]                                        cell_sum;
	acqres_pkg::acqres_apb_state_t                      state;
	acqres_pkg::acqres_apb_state_t                      next_state;
	logic [31:0]                                        prdata_q;
	logic                                               pslverr_q;
	logic [31:0]                                        next_rdata;
	logic [7:0]                                         req_idx;
	logic                                               setup_phase;
	logic                                               access_done;
	logic                                               wr_done;

	// ----------------------------------------------------------------
	// address decode helpers
	// ----------------------------------------------------------------

	// register index from a byte address
	function automatic logic [7:0] acqres_index(input logic [11:0] addr);
		acqres_index = addr[9:2];
	endfunction : acqres_index

	// aligned address that falls on a register of this bank
	function automatic logic acqres_mapped(input logic [11:0] addr);
		logic [7:0] idx;
		idx           = addr[9:2];
		acqres_mapped = (addr[1:0] == 2'h0) && (addr[11:10] == 2'h0) &&
		                (idx >= `ACQRES_IDX_CELL_FIRST) && (idx <= `ACQRES_IDX_MEAS_EN);
	endfunction : acqres_mapped

	// index lies inside the read-only result bank
	function automatic logic acqres_is_result(input logic [7:0] idx);
		acqres_is_result = (idx >= `ACQRES_IDX_CELL_FIRST) && (idx <= `ACQRES_IDX_SUM);
	endfunction : acqres_is_result

	assign req_idx     = acqres_index(apb_req.paddr);
	assign setup_phase = apb_req.psel && !apb_req.penable;
	assign access_done = apb_req.psel && apb_req.penable && (state == acqres_pkg::ACQRES_ACCESS);
	assign wr_done     = access_done && apb_req.pwrite;

	// ----------------------------------------------------------------
	// apb phase tracking
	// ----------------------------------------------------------------

	// next phase from the master's strobes
	always_comb begin
		next_state = state;
		case (state)
			acqres_pkg::ACQRES_IDLE: begin
				if (setup_phase) begin
					next_state = acqres_pkg::ACQRES_ACCESS;
				end
			end
			acqres_pkg::ACQRES_ACCESS: begin
				if (setup_phase) begin
					next_state = acqres_pkg::ACQRES_ACCESS;
				end else if (!apb_req.psel || apb_req.penable) begin
					next_state = acqres_pkg::ACQRES_IDLE;
				end
			end
			default: begin
				next_state = acqres_pkg::ACQRES_IDLE;
			end
		endcase
	end

	// phase register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= acqres_pkg::ACQRES_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// result storage
	// ----------------------------------------------------------------

	// one left-justified word per channel; bus writes never reach these
	genvar g;
	generate
		for (g = 0; g < `ACQRES_NUM_RESULTS; g++) begin : g_result
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					result[g] <= `ACQRES_RESULT_RESET;
				end else if (meas.valid && (meas.channel == 4'(g))) begin
					if (g < `ACQRES_CH_AUX1) begin
						result[g] <= {meas.data[`ACQRES_HI_RES_W-1:0], 2'h0};
					end else begin
						result[g] <= {meas.data[`ACQRES_LO_RES_W-1:0], 4'h0};
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// cell total
	// ----------------------------------------------------------------

	// adder over the masked cell results
	acqres_sum u_sum (
		.cells  (result[`ACQRES_NUM_CELLS-1:0]),
		.enable (channel_measure_enable),
		.total  (sum_now)
	);

	// registered total, one cycle behind its inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_sum <= `ACQRES_SUM_RESET;
		end else begin
			cell_sum <= sum_now;
		end
	end

	// ----------------------------------------------------------------
	// measurement enable register
	// ----------------------------------------------------------------

	// the only writable register; result writes fall through silently
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_measure_enable <= `ACQRES_MEAS_EN_RESET;
		end else if (wr_done && acqres_mapped(apb_req.paddr) && (req_idx == `ACQRES_IDX_MEAS_EN)) begin
			channel_measure_enable <= apb_req.pwdata[`ACQRES_NUM_CELLS-1:0];
		end
	end

	// ----------------------------------------------------------------
	// read data and error
	// ----------------------------------------------------------------

	// read multiplexer, upper bits zero
	always_comb begin
		logic [7:0] off;
		off        = req_idx - `ACQRES_IDX_CELL_FIRST;
		next_rdata = 32'h0000_0000;
		if (!acqres_mapped(apb_req.paddr)) begin
			next_rdata = 32'h0000_0000;
		end else if (req_idx == `ACQRES_IDX_SUM) begin
			next_rdata = {16'h0000, cell_sum};
		end else if (req_idx == `ACQRES_IDX_MEAS_EN) begin
			next_rdata = {20'h0_0000, channel_measure_enable};
		end else begin
			next_rdata = {16'h0000, result[off[3:0]]};
		end
	end

	// answer is captured in the setup cycle and stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup_phase) begin
			prdata_q  <= apb_req.pwrite ? 32'h0000_0000 : next_rdata;
			pslverr_q <= !acqres_mapped(apb_req.paddr);
		end
	end

	// zero-wait answer
	assign apb_rsp.pready  = access_done;
	assign apb_rsp.prdata  = prdata_q;
	assign apb_rsp.pslverr = pslverr_q && access_done;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------

	logic any_result_set;
	logic result_read_setup;
	logic req_mapped;
	assign req_mapped        = acqres_mapped(apb_req.paddr);
	assign any_result_set    = |result;
	assign result_read_setup = setup_phase && !apb_req.pwrite && acqres_mapped(apb_req.paddr) &&
	                           acqres_is_result(req_idx);

	// a cell update lands in its own register, left-justified
	AST_CELL_UPDATE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(meas.valid && (meas.channel < 4'hC))
		|=> result[$past(meas.channel)] == {$past(meas.data), 2'h0}
	) else $error("cell result not stored at its channel");

	// a cell read answers with the stored word, low two bits zero
	AST_CELL_READ_LOW: assert property (
		@(posedge pclk) disable iff (!presetn)
		(result_read_setup && (req_idx <= `ACQRES_IDX_CELL_LAST) && !meas.valid)
		|=> (prdata_q[1:0] == 2'h0) && (prdata_q[31:16] == 16'h0000)
		    && (prdata_q[15:0] == result[$past(req_idx) - 8'h20])
	) else $error("cell read data wrong or low bits set");

	// stack update keeps fourteen bits in 15:2
	AST_STACK_UPDATE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(meas.valid && (meas.channel == `ACQRES_CH_STACK))
		|=> (result[12][15:2] == $past(meas.data)) && (result[12][1:0] == 2'h0)
	) else $error("stack result misplaced");

	// first aux update keeps twelve bits in 15:4
	AST_AUX1_UPDATE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(meas.valid && (meas.channel == `ACQRES_CH_AUX1))
		|=> (result[13][15:4] == $past(meas.data[11:0])) && (result[13][3:0] == 4'h0)
	) else $error("first aux result misplaced");

	// second aux update keeps twelve bits in 15:4
	AST_AUX2_UPDATE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(meas.valid && (meas.channel == `ACQRES_CH_AUX2))
		|=> (result[14][15:4] == $past(meas.data[11:0])) && (result[14][3:0] == 4'h0)
	) else $error("second aux result misplaced");

	// disabled cells add nothing to the total
	AST_SUM_MASKED: assert property (
		@(posedge pclk) disable iff (!presetn)
		(channel_measure_enable == 12'h000) [*2] |-> (cell_sum == 16'h0000)
	) else $error("total counts a disabled cell");

	// cell 0 alone enabled makes the total its upper twelve bits
	AST_SUM_SINGLE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(channel_measure_enable == 12'h001) |=> (cell_sum == {4'h0, $past(result[0][15:4])})
	) else $error("total differs from the one enabled cell");

	// results and the total read zero on the first edge after reset
	AST_RESET_ZERO: assert property (
		@(posedge pclk)
		$rose(presetn) |-> (!any_result_set && (cell_sum == 16'h0000))
	) else $error("result bank not zero after reset");

	// writes to the result bank leave state untouched
	AST_WRITE_IGNORED: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_done && acqres_is_result(req_idx) && !meas.valid)
		|=> $stable(result) && $stable(channel_measure_enable)
	) else $error("write to result bank changed state");

	// setup is followed by a ready access with no wait
	AST_ZERO_WAIT: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_phase ##1 (apb_req.psel && apb_req.penable) |-> apb_rsp.pready
	) else $error("access phase not answered at once");

	// a result read never shows anything above bit 15
	AST_RESULT_UPPER_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		result_read_setup
		|=> (prdata_q[31:16] == 16'h0000)
	) else $error("result read shows bits above 15");

	// a stack read keeps its two low bits at zero
	AST_STACK_READ_LOW: assert property (
		@(posedge pclk) disable iff (!presetn)
		(result_read_setup && (req_idx == `ACQRES_IDX_STACK))
		|=> (prdata_q[1:0] == 2'h0)
	) else $error("stack read shows low bits set");

	// a first aux read keeps its four low bits at zero
	AST_AUX1_READ_LOW: assert property (
		@(posedge pclk) disable iff (!presetn)
		(result_read_setup && (req_idx == `ACQRES_IDX_AUX1))
		|=> (prdata_q[3:0] == 4'h0)
	) else $error("first aux read shows low bits set");

	// a second aux read keeps its four low bits at zero
	AST_AUX2_READ_LOW: assert property (
		@(posedge pclk) disable iff (!presetn)
		(result_read_setup && (req_idx == `ACQRES_IDX_AUX2))
		|=> (prdata_q[3:0] == 4'h0)
	) else $error("second aux read shows low bits set");

	// a total read answers with the registered sum
	AST_SUM_READ: assert property (
		@(posedge pclk) disable iff (!presetn)
		(result_read_setup && (req_idx == `ACQRES_IDX_SUM))
		|=> (prdata_q == {16'h0000, $past(cell_sum)})
	) else $error("total read differs from the sum");

	// the total settles once its inputs stop moving
	AST_SUM_STEADY: assert property (
		@(posedge pclk) disable iff (!presetn)
		($stable(result) && $stable(channel_measure_enable))
		|=> $stable(cell_sum)
	) else $error("total moved with steady inputs");

	// results change only through a measurement update
	AST_RESULT_HOLDS: assert property (
		@(posedge pclk) disable iff (!presetn)
		!meas.valid
		|=> $stable(result)
	) else $error("result changed without an update");

	// a write to the result bank completes without error
	AST_RESULT_WRITE_OKAY: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_done && req_mapped && (req_idx <= `ACQRES_IDX_SUM))
		|-> !apb_rsp.pslverr
	) else $error("write to result bank flagged an error");

	// an unmapped or misaligned access is flagged in its access phase
	AST_UNMAPPED_ERROR: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_phase && !req_mapped) ##1 access_done
		|-> apb_rsp.pslverr
	) else $error("unmapped access not flagged");

	// a write answer carries no read data
	AST_WRITE_READS_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup_phase && apb_req.pwrite)
		|=> (prdata_q == 32'h0000_0000)
	) else $error("write answer carries data");

	// the unused channel code leaves every result alone
	AST_IGNORED_CHANNEL: assert property (
		@(posedge pclk) disable iff (!presetn)
		(meas.valid && (meas.channel == 4'hF))
		|=> $stable(result)
	) else $error("ignored channel changed a result");

	// a write to the enable register lands at its access edge
	AST_EN_WRITE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_done && req_mapped && (req_idx == `ACQRES_IDX_MEAS_EN))
		|=> (channel_measure_enable == $past(apb_req.pwdata[11:0]))
	) else $error("enable register write lost");

endmodule : acqres_regs

/* dv/acqres_host.sv */
// apb host model that reads and writes the result bank
`timescale 1ns/1ns

module acqres_host (
	// clock
	input  wire logic                        pclk,
	// apb master side
	output acqres_pkg::acqres_apb_req_t      apb_req,
	input  wire acqres_pkg::acqres_apb_rsp_t apb_rsp
);
	logic hung; // a transfer never saw pready

	initial begin
		apb_req = '0;
		hung    = 1'b0;
	end

	// ----------------------------------------------------------------
	// one transfer, held until pready is sampled high or 16 access cycles pass
	// ----------------------------------------------------------------
	task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err);
		int   n;
		logic rdy;
		n = 0;
		apb_req <= acqres_pkg::acqres_apb_req_t'{1'b1, 1'b0, wr, addr, wdata};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		// answer is taken at the rising edge where pready is sampled high
		do begin
			@(posedge pclk);
			rdy   = apb_rsp.pready;
			rdata = apb_rsp.prdata;
			err   = apb_rsp.pslverr;
			n++;
		end while (rdy !== 1'b1 && n < 16);
		if (rdy !== 1'b1)
			hung = 1'b1;
		apb_req <= '0;
		@(posedge pclk); // idle cycle so the next setup is a fresh step
	endtask : xfer
endmodule : acqres_host

/* dv/testbench.sv */
// self-checking bench for the acquisition result bank
`timescale 1ns/1ns

module testbench;
	// ----------------------------------------------------------------
	// clock, design and host
	// ----------------------------------------------------------------
	logic                        pclk;
	logic                        presetn;
	acqres_pkg::acqres_apb_req_t apb_req;
	acqres_pkg::acqres_apb_rsp_t apb_rsp;
	acqres_pkg::acqres_meas_t    meas;
	logic [15:0]                 res [15];
	logic [11:0]                 en;
	logic [31:0]                 rdata;
	logic [31:0]                 wv;
	logic                        err;
	int                          seed;
	int                          n_fail;
	int                          num_checks;

	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	acqres_regs u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .meas(meas));
	acqres_host u_host (.pclk(pclk), .apb_req(apb_req), .apb_rsp(apb_rsp));

	// ----------------------------------------------------------------
	// compares, verdict and expectations
	// ----------------------------------------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_flag

	task automatic give_verdict;
		if (n_fail == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict

	function automatic logic [15:0] f_word(input logic [3:0] ch, input logic [13:0] d);
		return (ch == 4'hD || ch == 4'hE) ? {d[11:0], 4'h0} : {d, 2'b00};
	endfunction : f_word

	function automatic logic [15:0] f_sum();
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 12; i++)
			if (en[i])
				s += {4'h0, res[i][15:4]};
		return s;
	endfunction : f_sum

	// ----------------------------------------------------------------
	// bus and update helpers
	// ----------------------------------------------------------------
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		u_host.xfer(wr, a, wd, rdata, err);
		if (u_host.hung) begin
			n_fail++;
			give_verdict();
		end
	endtask : bus

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
		bus(1'b0, a, 32'h0000_0000);
		chk_word(rdata, e);
		chk_flag(err, ee);
	endtask : rd

	task automatic read_all;
		for (int i = 0; i < 15; i++)
			rd(12'(32'h80 + 4 * i), {16'h0000, res[i]}, 1'b0);
		rd(12'hBC, {16'h0000, f_sum()}, 1'b0);
		rd(12'hC0, {20'h00000, en}, 1'b0);
	endtask : read_all

	task automatic upd(input logic [3:0] ch, input logic [13:0] d);
		meas <= acqres_pkg::acqres_meas_t'{1'b1, ch, d};
		if (ch != 4'hF)
			res[ch] = f_word(ch, d);
		@(posedge pclk);
	endtask : upd

	task automatic clear_model;
		en = 12'hFFF;
		foreach (res[i])
			res[i] = 16'h0000;
	endtask : clear_model

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed       = 64911;
		n_fail     = 0;
		num_checks = 0;
		presetn    = 1'b0;
		meas       = '0;
		clear_model();
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		read_all();
		// back-to-back random updates, enable changes, total tracking
		for (int k = 0; k < 40; k++) begin
			upd(4'($unsigned($random(seed))), 14'($unsigned($random(seed))));
			upd(4'($unsigned($random(seed))), 14'($unsigned($random(seed))));
			meas.valid <= 1'b0;
			repeat (2) @(posedge pclk);
			if (k % 8 == 7) begin
				wv = (k == 15) ? 32'h0000_0000 : (k == 23) ? 32'h0000_0001 : $random(seed);
				bus(1'b1, 12'hC0, wv);
				en = wv[11:0];
			end
			if (k % 10 == 9)
				read_all();
			else
				rd(12'hBC, {16'h0000, f_sum()}, 1'b0);
		end
		// writes to every result register are ignored without error
		for (int i = 0; i < 16; i++) begin
			bus(1'b1, 12'(32'h80 + 4 * i), $random(seed));
			chk_flag(err, 1'b0);
		end
		repeat (2) @(posedge pclk);
		read_all();
		// unmapped and misaligned places
		rd(12'hC4, 32'h0000_0000, 1'b1);
		rd(12'h82, 32'h0000_0000, 1'b1);
		rd(12'h7C, 32'h0000_0000, 1'b1);
		// second reset in mid-run zeroes every result and the total, and sets all twelve enables again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		clear_model();
		@(posedge pclk);
		read_all();
		give_verdict();
	end
endmodule : testbench
